// *** paalm_top.sv ***
// Alarm latch manager with AXI4-Lite register access
// Summary of operation
// - Active alarms flash beacon and their numbers in rotation.
// - Alarm outputs switch in alarm; per-output polarity setting.
// - Reset default: non-latching, relay de-energised in alarm.
// - Acknowledge from parameter, two inputs, or function buttons.
// - Acknowledge while present: beacon steady, number still flashes.
// - Non-latching clears itself when condition goes away.
// - Auto latch needs acknowledge; early acknowledge clears on removal.
// - Auto latch removed unacknowledged stays on until acknowledge.
// - Manual latch: acknowledge only after condition cleared.
// - Manual latch cleared without acknowledge keeps showing alarm.
// - Output-only follows condition; no beacon, no latching.
// - Each alarm has its own state machine; the three current alarms share one latch type.
// - Blocking suppresses alarm until process first reaches safe.
// - Blocking re-armed at power-up and leaving configuration.
// - Hysteresis offsets release threshold from trip threshold.
// - Sensor break: on, latching, or off.
// - Latching sensor break behaves as manual latch.
// - Sensor break in auto: output goes to safe level.
// - Sensor break in manual: keep manual level.
// - Sensor break in standby: outputs forced fully off.
// - Loop break if PV moves under half band in loop time.
// - Loop time loaded as twelve derivative times after tune.
// - Loop break self-clears; acknowledge makes beacon steady.
// - Three current alarms: load, leakage, overcurrent.
// - Comparisons: absolute low/high, deviation low/high, band.
`timescale 1ns/100ps
module paalm_top
  import paalm_pkg::*;
#(
  parameter int NALM = 8,
  parameter int LB_TICK_CYC = TICK_CYC,
  parameter int FL_TICK_CYC = TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] digital_input_ack,
  input wire logic function_button_one,
  input wire logic function_button_two,
  input wire logic function_button_page,
  input wire logic sensor_open,
  input wire logic tune_done,
  output logic alarm_beacon,
  output logic [2:0] alarm_number,
  output logic alarm_number_on,
  output logic [NALM-1:0] relay_out,
  output logic sensor_break_message,
  output logic loop_break_message,
  output logic [15:0] output_demand
);
  import paalm_pkg::*;

  // Indices 3..7 are hard wired, so only eight alarms fit
  if (NALM != 8) begin : g_bad_nalm
    $error("NALM must be 8");
  end
  if (LB_TICK_CYC < 1 || FL_TICK_CYC < 1) begin : g_bad_tick
    $error("tick counts must be positive");
  end

  // Alarm index: 0..2 process, 3 sensor break, 4 loop break, 5..7 current
  logic [31:0] ctrl_r, alcfg_r, hyst_r, pv_r, sp_r, loop_r, cur_r, outlvl_r;
  logic [31:0] ackcfg_r;
  logic [15:0] thr_r [3];
  logic [31:0] cthr_r;
  logic ack_par;
  logic cfg_lvl_r, cfg_fall;
  logic [1:0] sbr_mode, op_mode;
  logic [NALM-1:0] cond, latched, ackd_steady, vis, relay_pol;
  paalm_st_t st_r [NALM];
  logic [NALM-1:0] block_r;
  logic [1:0] lat_t [NALM];
  logic [2:0] cmp_t [3];

  assign sbr_mode = ctrl_r[2:1];
  assign op_mode = ctrl_r[4:3];
  assign relay_pol = ctrl_r[23:16];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lat_t[i] = alcfg_r[i*8 +: 2];
      cmp_t[i] = alcfg_r[i*8+2 +: 3];
    end
    lat_t[3] = (sbr_mode == SBR_LATCH) ? LAT_MAN : LAT_NONE;
    lat_t[4] = LAT_NONE;
    for (int i = 5; i < 8; i++) lat_t[i] = alcfg_r[24 +: 2];
  end

  // AXI4-Lite write channel
  logic aw_h, w_h;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_h && !s_axi_bvalid && !s_axi_awready;
      s_axi_wready <= !w_h && !s_axi_bvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h <= 1'b1;
        aw_a <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h <= 1'b1;
        w_d <= s_axi_wdata;
      end
      if (aw_h && w_h && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_a > OFS_ACKCFG || aw_a[1:0] != 2'h0) ? 2'h2 : 2'h0;
        aw_h <= 1'b0;
        w_h <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  logic wr_go;
  assign wr_go = aw_h && w_h && !s_axi_bvalid;

  // Register file; byte enables ignored, whole-word writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 32'h0000_0000;
      alcfg_r <= ALCFG_RST;
      thr_r[0] <= 16'h0000;
      thr_r[1] <= 16'h0000;
      thr_r[2] <= 16'h0000;
      hyst_r <= 32'h0000_0000;
      pv_r <= 32'h0000_0000;
      sp_r <= 32'h0000_0000;
      loop_r <= 32'h0000_0000;
      cur_r <= 32'h0000_0000;
      cthr_r <= 32'h0000_0000;
      outlvl_r <= {16'h0000, SAFE_RST};
      ackcfg_r <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        case (aw_a)
          OFS_CTRL: ctrl_r <= w_d;
          OFS_ALCFG: alcfg_r <= w_d;
          OFS_THR0: thr_r[0] <= w_d[15:0];
          OFS_THR1: thr_r[1] <= w_d[15:0];
          OFS_THR2: thr_r[2] <= w_d[15:0];
          OFS_HYST: hyst_r <= w_d;
          OFS_PV: pv_r <= w_d;
          OFS_SP: sp_r <= w_d;
          OFS_LOOP: loop_r <= w_d;
          OFS_CUR: cur_r <= w_d;
          OFS_CTHR: cthr_r <= w_d;
          OFS_OUTLVL: outlvl_r <= w_d;
          OFS_ACKCFG: ackcfg_r <= w_d;
          default: ;
        endcase
      end
      if (tune_done) begin
        loop_r[15:0] <= 16'(loop_r[31:24] * LBT_MULT);
      end
    end
  end
  // Acknowledge parameter: write 1 to CTRL bit 0, self-clearing pulse
  assign ack_par = wr_go && aw_a == OFS_CTRL && w_d[0];
  assign cfg_fall = cfg_lvl_r && !ctrl_r[5];
  always_ff @(posedge aclk) begin
    if (!aresetn) cfg_lvl_r <= 1'b0;
    else cfg_lvl_r <= ctrl_r[5];
  end

  // Read channel
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      OFS_CTRL: rd_mux = {ctrl_r[31:1], 1'b0};
      OFS_ALCFG: rd_mux = alcfg_r;
      OFS_THR0: rd_mux = {16'h0000, thr_r[0]};
      OFS_THR1: rd_mux = {16'h0000, thr_r[1]};
      OFS_THR2: rd_mux = {16'h0000, thr_r[2]};
      OFS_HYST: rd_mux = hyst_r;
      OFS_PV: rd_mux = pv_r;
      OFS_SP: rd_mux = sp_r;
      OFS_LOOP: rd_mux = loop_r;
      OFS_CUR: rd_mux = cur_r;
      OFS_CTHR: rd_mux = cthr_r;
      OFS_OUTLVL: rd_mux = outlvl_r;
      OFS_STAT: rd_mux = {8'h00, block_r, cond, vis};
      OFS_DEMAND: rd_mux = {16'h0000, output_demand};
      OFS_ACKCFG: rd_mux = ackcfg_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (s_axi_araddr > OFS_ACKCFG ||
                        s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Acknowledge sources, rising edge only so a held button acts once
  logic [4:0] ack_in, ack_prev_r;
  logic ack_ev;
  assign ack_in = {function_button_page, function_button_two,
                   function_button_one, digital_input_ack} & ackcfg_r[4:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) ack_prev_r <= 5'h00;
    else ack_prev_r <= ack_in;
  end
  assign ack_ev = ack_par || |(ack_in & ~ack_prev_r);

  // Process alarm comparisons with hysteresis
  logic signed [15:0] pv, sp, hy, dv;
  logic [2:0] pcond_r;
  assign pv = signed'(pv_r[15:0]);
  assign sp = signed'(sp_r[15:0]);
  assign hy = signed'(hyst_r[15:0]);
  assign dv = 16'(pv - sp);
  always_ff @(posedge aclk) begin
    if (!aresetn) pcond_r <= 3'h0;
    else begin
      for (int i = 0; i < 3; i++) begin
        logic signed [15:0] t;
        logic lo, hi;
        t = signed'(thr_r[i]);
        lo = pcond_r[i] ? (pv < 16'(t + hy)) : (pv < t);
        hi = pcond_r[i] ? (pv > 16'(t - hy)) : (pv > t);
        case (cmp_t[i])
          CMP_ABS_LO: pcond_r[i] <= lo;
          CMP_ABS_HI: pcond_r[i] <= hi;
          CMP_DEV_LO: pcond_r[i] <= pcond_r[i] ? (dv < 16'(hy - t))
                                                : (dv < -t);
          CMP_DEV_HI: pcond_r[i] <= pcond_r[i] ? (dv > 16'(t - hy))
                                                : (dv > t);
          CMP_BAND: pcond_r[i] <= pcond_r[i]
              ? (dv > 16'(t - hy) || dv < 16'(hy - t)) : (dv > t || dv < -t);
          default: pcond_r[i] <= 1'b0;
        endcase
      end
    end
  end

  // Loop break timer: PV must move half the proportional band
  logic [31:0] lb_pre_r;
  logic [15:0] lb_cnt_r;
  logic signed [15:0] lb_ref_r, lb_mv, lb_half;
  logic lb_r, lb_tick;
  // Signed threshold, else a small fall in PV looks like a big move
  assign lb_half = signed'(16'(loop_r[22:16] >> 1));
  assign lb_tick = lb_pre_r == 32'(LB_TICK_CYC - 1);
  assign lb_mv = 16'(pv - lb_ref_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lb_pre_r <= 32'h0000_0000;
      lb_cnt_r <= 16'h0000;
      lb_ref_r <= 16'sh0000;
      lb_r <= 1'b0;
    end else begin
      lb_pre_r <= lb_tick ? 32'h0000_0000 : lb_pre_r + 32'h0000_0001;
      if (loop_r[23] || loop_r[15:0] == 16'h0000) begin
        lb_r <= 1'b0; // On/off control: inhibited
        lb_cnt_r <= 16'h0000;
        lb_ref_r <= pv;
      end else if ((lb_mv > lb_half) || (-lb_mv > lb_half)) begin
        lb_r <= 1'b0;
        lb_cnt_r <= 16'h0000;
        lb_ref_r <= pv;
      end else if (lb_tick) begin
        if (lb_cnt_r >= loop_r[15:0] - 16'h0001) lb_r <= 1'b1;
        else lb_cnt_r <= lb_cnt_r + 16'h0001;
      end
    end
  end

  // Raw conditions per alarm
  always_comb begin
    cond[2:0] = pcond_r;
    cond[3] = sensor_open && sbr_mode != SBR_OFF;
    cond[4] = lb_r;
    cond[5] = cur_r[15:0] < cthr_r[15:0];
    cond[6] = cur_r[31:16] > {8'h00, cthr_r[23:16]};
    cond[7] = cur_r[15:0] > {cthr_r[31:24], 8'h00};
  end

  // Independent state machine per alarm
  genvar g;
  generate
    for (g = 0; g < NALM; g++) begin : g_alm
      logic c;
      assign c = cond[g] && !block_r[g];
      always_ff @(posedge aclk) begin
        if (!aresetn || cfg_fall) block_r[g] <= 1'b1;
        else if (!cond[g] || !ctrl_r[8+g]) block_r[g] <= 1'b0;
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) st_r[g] <= PA_IDLE;
        else begin
          case (st_r[g])
            PA_IDLE: if (c) st_r[g] <= PA_ACT;
            PA_ACT: begin
              if (!c && lat_t[g] inside {LAT_NONE, LAT_OUTONLY})
                st_r[g] <= PA_IDLE;
              else if (!c) st_r[g] <= PA_SAFE;
              else if (ack_ev && lat_t[g] != LAT_OUTONLY &&
                       lat_t[g] != LAT_MAN)
                st_r[g] <= PA_ACKD;
            end
            PA_ACKD: if (!c) st_r[g] <= PA_IDLE;
            PA_SAFE: begin
              if (c) st_r[g] <= PA_ACT;
              else if (ack_ev) st_r[g] <= PA_IDLE;
            end
            default: st_r[g] <= PA_IDLE;
          endcase
        end
      end
      assign latched[g] = st_r[g] != PA_IDLE;
      assign ackd_steady[g] = st_r[g] == PA_ACKD;
      assign vis[g] = latched[g] && lat_t[g] != LAT_OUTONLY;
    end
  endgenerate

  // Flash and rotation
  logic [31:0] tick_r;
  logic [15:0] fl_r, rot_r;
  logic flash_r, tick;
  logic [2:0] idx_r;
  assign tick = tick_r == 32'(FL_TICK_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_r <= 32'h0000_0000;
      fl_r <= 16'h0000;
      rot_r <= 16'h0000;
      flash_r <= 1'b0;
      idx_r <= 3'h0;
    end else begin
      tick_r <= tick ? 32'h0000_0000 : tick_r + 32'h0000_0001;
      if (tick) begin
        fl_r <= (fl_r == 16'(FLASH_TICKS - 1)) ? 16'h0000 : fl_r + 16'h0001;
        if (fl_r == 16'(FLASH_TICKS - 1)) flash_r <= !flash_r;
        rot_r <= (rot_r == 16'(ROT_TICKS - 1)) ? 16'h0000 : rot_r + 16'h0001;
      end
      if (!vis[idx_r] || (tick && rot_r == 16'(ROT_TICKS - 1)))
        idx_r <= idx_r + 3'h1;
    end
  end

  // Outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_beacon <= 1'b0;
      alarm_number <= 3'h0;
      alarm_number_on <= 1'b0;
      relay_out <= '0;
      sensor_break_message <= 1'b0;
      loop_break_message <= 1'b0;
      output_demand <= 16'h0000;
    end else begin
      // Beacon steady only if every shown alarm is acknowledged
      alarm_beacon <= |vis && (flash_r || (vis & ~ackd_steady) == '0);
      alarm_number <= idx_r;
      alarm_number_on <= vis[idx_r] && flash_r;
      // Polarity 0: relay de-energised in alarm, fail-safe on power loss
      relay_out <= relay_pol ~^ latched;
      sensor_break_message <= latched[3] && flash_r;
      loop_break_message <= latched[4] && flash_r;
      if (latched[3] && op_mode == MODE_OFF) output_demand <= 16'h0000;
      else if (op_mode == MODE_MAN) output_demand <= outlvl_r[31:16];
      else if (latched[3]) output_demand <= outlvl_r[15:0];
      else if (lb_r) output_demand <= ctrl_r[6] ? 16'h7FFF : 16'h8000;
      else output_demand <= 16'h0000;
    end
  end

  chk_manual_noack: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r[0] == PA_ACT && lat_t[0] == LAT_MAN |=> st_r[0] != PA_ACKD)
    else $error("manual alarm acknowledged while present");
  chk_relay_pol: assert property (@(posedge aclk) disable iff (!aresetn)
    latched[0] && !relay_pol[0] |=> !relay_out[0])
    else $error("relay not de-energised in alarm");
  chk_auto_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r[0] == PA_SAFE && !ack_ev && !cond[0] |=> st_r[0] == PA_SAFE)
    else $error("latched alarm released without acknowledge");
  chk_standby_off: assert property (@(posedge aclk) disable iff (!aresetn)
    latched[3] && op_mode == MODE_OFF |=> output_demand == 16'h0000)
    else $error("standby output not off");
  chk_ack_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_in == ack_prev_r && !ack_par |-> !ack_ev)
    else $error("held input gave acknowledge");
  chk_block_rearm: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_fall |=> block_r == 8'hFF)
    else $error("blocking not re-armed");
  chk_outonly_hide: assert property (@(posedge aclk) disable iff (!aresetn)
    lat_t[0] == LAT_OUTONLY |-> !vis[0])
    else $error("output-only alarm shown");
  chk_safe_level: assert property (@(posedge aclk) disable iff (!aresetn)
    latched[3] && op_mode == MODE_AUTO |=> output_demand == $past(outlvl_r[15:0]))
    else $error("safe level not applied");
endmodule

// *** paalm_pkg.sv ***
// Package of constants for the process alarm latch manager
package paalm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ALCFG = 8'h04;
  localparam logic [7:0] OFS_THR0 = 8'h08;
  localparam logic [7:0] OFS_THR1 = 8'h0C;
  localparam logic [7:0] OFS_THR2 = 8'h10;
  localparam logic [7:0] OFS_HYST = 8'h14;
  localparam logic [7:0] OFS_PV = 8'h18;
  localparam logic [7:0] OFS_SP = 8'h1C;
  localparam logic [7:0] OFS_LOOP = 8'h20;
  localparam logic [7:0] OFS_CUR = 8'h24;
  localparam logic [7:0] OFS_CTHR = 8'h28;
  localparam logic [7:0] OFS_OUTLVL = 8'h2C;
  localparam logic [7:0] OFS_STAT = 8'h30;
  localparam logic [7:0] OFS_DEMAND = 8'h34;
  localparam logic [7:0] OFS_ACKCFG = 8'h38;
  // Latch types (2 bits)
  localparam logic [1:0] LAT_NONE = 2'h0;
  localparam logic [1:0] LAT_AUTO = 2'h1;
  localparam logic [1:0] LAT_MAN = 2'h2;
  localparam logic [1:0] LAT_OUTONLY = 2'h3;
  // Comparison types (3 bits)
  localparam logic [2:0] CMP_ABS_LO = 3'h0;
  localparam logic [2:0] CMP_ABS_HI = 3'h1;
  localparam logic [2:0] CMP_DEV_LO = 3'h2;
  localparam logic [2:0] CMP_DEV_HI = 3'h3;
  localparam logic [2:0] CMP_BAND = 3'h4;
  // Sensor break settings
  localparam logic [1:0] SBR_ON = 2'h0;
  localparam logic [1:0] SBR_LATCH = 2'h1;
  localparam logic [1:0] SBR_OFF = 2'h2;
  // Operating modes
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_MAN = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h2;
  // Reset values and loop time multiplier
  localparam logic [31:0] ALCFG_RST = 32'h0000_0000;
  localparam logic [15:0] SAFE_RST = 16'h0000;
  localparam logic [15:0] LBT_MULT = 16'h000C;
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int ROT_MS = 1000;
  localparam int FLASH_MS = 500;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int ROT_TICKS = ROT_MS / TICK_MS;
  localparam int FLASH_TICKS = FLASH_MS / TICK_MS;
  typedef enum logic [3:0] {
    PA_IDLE = 4'b0001,
    PA_ACT = 4'b0010,
    PA_ACKD = 4'b0100,
    PA_SAFE = 4'b1000
  } paalm_st_t;
endpackage

// *** paalm_operator.sv ***
// Operator panel model: acknowledge buttons and digital inputs
`timescale 1ns/100ps
module paalm_operator #(
  parameter int HOLD = 60
) (
  input wire logic aclk,
  input wire logic [4:0] press_req,
  output logic [1:0] digital_input_ack,
  output logic function_button_one,
  output logic function_button_two,
  output logic function_button_page
);
  logic [4:0] held_r = 5'h00;
  int cnt_r = 0;
  // A press spans many clocks, as a hand would
  always_ff @(posedge aclk) begin
    if (|press_req) begin
      held_r <= press_req;
      cnt_r <= HOLD;
    end else if (cnt_r > 1)
      cnt_r <= cnt_r - 1;
    else
      held_r <= 5'h00;
  end
  // Released contacts fall low through their pull-downs
  assign digital_input_ack = held_r[1:0];
  assign function_button_one = held_r[2];
  assign function_button_two = held_r[3];
  assign function_button_page = held_r[4];
endmodule

// *** tb_paalm_top.sv ***
// Testbench for the process alarm latch manager
`timescale 1ns/100ps
module tb_paalm_top;
  import paalm_pkg::*;
  typedef struct {logic [1:0] k; logic [31:0] v; logic [31:0] m;
    logic [1:0] r;} paalm_note_t;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] press_req = 5'h00;
  logic [1:0] di;
  logic f1, f2, fp, beacon, anum_on, sbm, lbm;
  logic sensor_open = 0;
  logic tune = 0;
  logic [2:0] anum;
  logic [7:0] relay;
  logic [15:0] demand;
  logic peek = 0;
  logic [31:0] ctrl_v = 32'h0;
  logic [15:0] rnd;
  logic [15:0] on_v [5] = '{16'h0032, 16'h012C, 16'h0320, 16'h04B0,
    16'h0320};
  logic [15:0] off_v [5] = '{16'h012C, 16'h0032, 16'h03E8, 16'h03E8,
    16'h03E8};
  int errors = 0, checks = 0, cyc = 0, seed = 72216;
  paalm_note_t q[$];

  always #5 aclk = ~aclk;

  paalm_top #(.LB_TICK_CYC(2), .FL_TICK_CYC(2)) i_paalm_top (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .digital_input_ack(di),
    .function_button_one(f1), .function_button_two(f2),
    .function_button_page(fp), .sensor_open(sensor_open),
    .tune_done(tune), .alarm_beacon(beacon), .alarm_number(anum),
    .alarm_number_on(anum_on), .relay_out(relay),
    .sensor_break_message(sbm), .loop_break_message(lbm),
    .output_demand(demand));

  paalm_operator #(.HOLD(60)) i_paalm_operator (.aclk(aclk),
    .press_req(press_req), .digital_input_ack(di),
    .function_button_one(f1), .function_button_two(f2),
    .function_button_page(fp));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Oldest note meets the next read answer or port snapshot
  always @(posedge aclk) begin : mon
    paalm_note_t n;
    if ((rvalid && rready) || peek) begin
      n = q.pop_front();
      case (n.k)
        2'h0: begin
          check(rdata & n.m, n.v);
          check({30'h0, rresp}, {30'h0, n.r});
        end
        2'h1: check({24'h0, relay} & n.m, n.v);
        2'h2: check({25'h0, sbm, lbm, anum_on, anum, beacon} & n.m, n.v);
        default: check({16'h0, demand}, n.v);
      endcase
    end
  end

  // Generous ceiling; the sequence needs a few thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      end_sim();
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1;
        awvalid <= 0;
      end
      if (wready && !wd) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] v,
      input logic [31:0] m, input logic [1:0] r);
    q.push_back('{2'h0, v, m, r});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
  endtask

  task pk(input logic [1:0] k, input logic [31:0] v, input logic [31:0] m);
    repeat (4) @(posedge aclk);
    q.push_back('{k, v, m, 2'h0});
    @(posedge aclk);
    peek <= 1;
    @(posedge aclk);
    peek <= 0;
  endtask

  task rl(input logic [7:0] v, input logic [7:0] m);
    pk(2'h1, {24'h0, v & m}, {24'h0, m});
  endtask

  task pv(input logic [15:0] v);
    wr(OFS_PV, {16'h0, v});
  endtask

  task ctl(input logic [31:0] v);
    ctrl_v = v;
    wr(OFS_CTRL, v);
  endtask

  task press(input int s);
    @(posedge aclk);
    press_req <= 5'h01 << s;
    @(posedge aclk);
    press_req <= 5'h00;
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rl(8'hFF, 8'hFF);
    rd(OFS_ALCFG, 32'h0, 32'hFFFF_FFFF, 2'h0);
    rd(OFS_CTRL, 32'h0, 32'h00FF_0000, 2'h0);
    rd(8'h3C, 32'h0, 32'hFFFF_FFFF, 2'h2);
    // On/off control keeps loop break out of the way
    wr(OFS_LOOP, 32'h0080_0000);
    wr(OFS_ACKCFG, 32'h0000_001F);
    wr(OFS_THR0, 32'h0000_0064);
    wr(OFS_HYST, 32'h0000_000A);
    wr(OFS_SP, 32'h0000_03E8);
    $display("test reset done");
    for (int t = 0; t < 5; t++) begin
      rnd = 16'($random(seed) & 31);
      wr(OFS_ALCFG, {24'h0, 3'h0, 3'(t), LAT_NONE});
      pv(off_v[t]);
      rl(8'h01, 8'h01);
      pv(on_v[t] + rnd);
      rl(8'h00, 8'h01);
      pv(off_v[t]);
      rl(8'h01, 8'h01);
    end
    $display("test compare types done");
    wr(OFS_ALCFG, 32'h0000_0004);
    pv(16'h012C);
    wr(OFS_CTRL, ctrl_v | 32'h1);
    pk(2'h2, 32'h1, 32'h1);
    rl(8'h00, 8'h01);
    pv(16'h005F);
    rl(8'h00, 8'h01);
    pv(16'h0055);
    rl(8'h01, 8'h01);
    pv(16'h005F);
    rl(8'h01, 8'h01);
    ctl(32'h0001_0000);
    pv(16'h012C);
    rl(8'h01, 8'h01);
    pv(16'h0032);
    rl(8'h00, 8'h01);
    ctl(32'h0);
    $display("test non latching done");
    wr(OFS_ALCFG, 32'h0000_0005);
    pv(16'h012C);
    rl(8'h00, 8'h01);
    pv(16'h0032);
    rl(8'h00, 8'h01);
    press(0);
    rl(8'h01, 8'h01);
    pv(16'h012C);
    pv(16'h0032);
    rl(8'h00, 8'h01);
    repeat (70) @(posedge aclk);
    press(1);
    rl(8'h01, 8'h01);
    pv(16'h012C);
    wr(OFS_CTRL, ctrl_v | 32'h1);
    pk(2'h2, 32'h1, 32'h1);
    rl(8'h00, 8'h01);
    pv(16'h0032);
    rl(8'h01, 8'h01);
    $display("test auto latch done");
    wr(OFS_ALCFG, 32'h0000_0006);
    for (int s = 0; s < 5; s++) begin
      pv(16'h012C);
      press(s);
      rl(8'h00, 8'h01);
      repeat (70) @(posedge aclk);
      pv(16'h0032);
      rl(8'h00, 8'h01);
      press(s);
      rl(8'h01, 8'h01);
      repeat (70) @(posedge aclk);
    end
    $display("test manual latch done");
    wr(OFS_ALCFG, 32'h0000_0007);
    pv(16'h012C);
    rl(8'h00, 8'h01);
    pk(2'h2, 32'h0, 32'h1);
    wr(OFS_CTRL, ctrl_v | 32'h1);
    pv(16'h0032);
    rl(8'h01, 8'h01);
    $display("test output only done");
    wr(OFS_ALCFG, 32'h0000_0004);
    ctl(32'h0000_0120);
    // Leave configuration while in alarm so the rearm has work to do
    pv(16'h012C);
    ctl(32'h0000_0100);
    rl(8'h01, 8'h01);
    pv(16'h0032);
    pv(16'h012C);
    rl(8'h00, 8'h01);
    pv(16'h0032);
    ctl(32'h0);
    $display("test blocking done");
    wr(OFS_OUTLVL, 32'h0014_FFCE);
    @(posedge aclk) sensor_open <= 1;
    rl(8'h00, 8'h08);
    pk(2'h3, 32'h0000_FFCE, 32'hFFFF_FFFF);
    ctl(32'h0000_0008);
    pk(2'h3, 32'h0000_0014, 32'hFFFF_FFFF);
    ctl(32'h0000_0010);
    pk(2'h3, 32'h0, 32'hFFFF_FFFF);
    ctl(32'h0000_0002);
    @(posedge aclk) sensor_open <= 0;
    rl(8'h00, 8'h08);
    wr(OFS_CTRL, ctrl_v | 32'h1);
    rl(8'h08, 8'h08);
    ctl(32'h0000_0004);
    @(posedge aclk) sensor_open <= 1;
    rl(8'h08, 8'h08);
    $display("test sensor break done");
    // Loop time comes only from a tune; band 20, PV held still
    wr(OFS_LOOP, 32'h0214_0000);
    @(posedge aclk) tune <= 1;
    @(posedge aclk) tune <= 0;
    rd(OFS_LOOP, 32'h0214_0018, 32'hFFFF_FFFF, 2'h0);
    repeat (60) @(posedge aclk);
    rl(8'h00, 8'h10);
    pk(2'h3, 32'h0000_8000, 32'hFFFF_FFFF);
    // Catch a fresh flash-on phase so the sample sits well inside it
    for (int w = 0; w < 1100 && lbm; w++) @(posedge aclk);
    for (int w = 0; w < 1100 && !lbm; w++) @(posedge aclk);
    pk(2'h2, 32'h0000_0039, 32'h0000_003F);
    wr(OFS_CTRL, ctrl_v | 32'h1);
    pk(2'h2, 32'h1, 32'h1);
    pv(16'h0050);
    rl(8'h10, 8'h10);
    $display("test loop break done");
    wr(OFS_CUR, 32'h0020_0005);
    wr(OFS_CTHR, 32'h0110_0010);
    rl(8'h80, 8'hE0);
    $display("test current alarms done");
    end_sim();
  end
endmodule
